//--- core/eidr_pkg.sv
package eidr_pkg;

  // ==========================================================================
  // Machine cycle and call timing
  // ==========================================================================
  // One machine cycle is six states; each state lasts one clock here.
  localparam int MC_STATES = 6;
  localparam int CALL_MC = 2;
  localparam int CALL_CLKS = CALL_MC * MC_STATES;
  localparam logic [3:0] CALL_LAST = 4'(CALL_CLKS - 1);
  localparam int MAX_EXT = 8;
  localparam int VID_W = 3;

  typedef enum logic [2:0] {
    EIDR_S1 = 3'b000,
    EIDR_S2 = 3'b001,
    EIDR_S3 = 3'b010,
    EIDR_S4 = 3'b011,
    EIDR_S5 = 3'b100,
    EIDR_S6 = 3'b101
  } eidr_mc_t;

  typedef enum logic [0:0] {
    EIDR_IDLE = 1'b0,
    EIDR_CALL = 1'b1
  } eidr_call_t;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] OFS_TRIGGER = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_PRIORITY = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_PROGRESS = 8'h10;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h14;
  localparam logic [7:0] OFS_EVT_MASK = 8'h18;
  localparam int GLOBAL_EN_BIT = 31;
  localparam int EVT_TAKEN_BIT = 0;
  localparam int EVT_LOST_BIT = 1;
  localparam int EVT_W = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [EVT_W-1:0] RST_EVT = 2'h0;

endpackage : eidr_pkg

//--- core/eidr_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module eidr_pin_sync #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous pins and their synchronised request levels
  input wire logic [WIDTH-1:0] pin_n,
  output logic [WIDTH-1:0] req
);

  // ==========================================================================
  // Two-stage synchroniser
  // ==========================================================================
  // Pins idle high, so the stages reset to the idle level.
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= {WIDTH{1'b1}};
      stable_r <= {WIDTH{1'b1}};
    end else begin
      meta_r <= pin_n;
      stable_r <= meta_r;
    end
  end

  // The request is the inverted, settled pin level.
  assign req = ~stable_r;

endmodule : eidr_pin_sync
`default_nettype wire

//--- core/eidr_top.sv
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: Each external source has its own trigger type select bit choosing level or falling-edge mode.
// R2: The source holds each pin level for at least one machine cycle so a sample catches it.
// R3: For edge mode the source holds the pin high one machine cycle and then low one machine cycle.
// R4: In edge mode a falling pin sets the request flag and taking the call clears it.
// R5: In level mode the source keeps the pin low until the call and releases it before returning.
// R6: Inverted pin levels are latched into the flags at state five and polled the next cycle.
// R7: An unblocked polled request starts a call that lasts exactly two machine cycles.
// R8: At least three whole machine cycles pass between a request and the first handler fetch.
// R9: A poll that is not in the final cycle of an instruction waits for that instruction to end.
// R10: A return or an enable or priority access lets one more instruction finish before vectoring. The code counts only enable or priority writes, not reads.
// R11: With a single source the response is more than three and less than nine machine cycles.
// R12: No request is taken while one of equal level runs, nor right after a return.
// R13: A request denied while blocked is forgotten if its flag has dropped by the next poll.
// R14: A high level request preempts a low level handler but low never preempts low.
// R15: Software may write the request flags with the same effect as the hardware.
module eidr_top import eidr_pkg::*; #(
  parameter int NUM_EXT = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External request pins, active low
  input wire logic [NUM_EXT-1:0] external_request_pin_n,
  // CPU sequencing, same clock
  input wire logic instr_last_cycle,
  input wire logic instr_special,
  input wire logic return_from_interrupt_instr,
  // Vectoring and interrupt outputs
  output logic call_active,
  output logic [VID_W-1:0] vector_id,
  output logic [1:0] level_in_progress,
  output logic irq
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Lowest index wins within a priority level.
  function automatic logic [VID_W-1:0] first_set(input logic [MAX_EXT-1:0] v);
    logic [VID_W-1:0] r;
    r = '0;
    for (int i = MAX_EXT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[VID_W-1:0];
      end
    end
    return r;
  endfunction : first_set

  // ==========================================================================
  // Pin sampling
  // ==========================================================================
  logic [NUM_EXT-1:0] req_s;

  // R2
  eidr_pin_sync #(.WIDTH(NUM_EXT)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_n(external_request_pin_n),
    .req(req_s)
  );

  // ==========================================================================
  // Machine cycle sequencer
  // ==========================================================================
  eidr_mc_t mc_r;
  logic s5_w, s6_w;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mc_r <= EIDR_S1;
    end else begin
      case (mc_r)
        EIDR_S1: mc_r <= EIDR_S2;
        EIDR_S2: mc_r <= EIDR_S3;
        EIDR_S3: mc_r <= EIDR_S4;
        EIDR_S4: mc_r <= EIDR_S5;
        EIDR_S5: mc_r <= EIDR_S6;
        default: mc_r <= EIDR_S1;
      endcase
    end
  end

  assign s5_w = (mc_r == EIDR_S5);
  assign s6_w = (mc_r == EIDR_S6);

  // ==========================================================================
  // Register bus
  // ==========================================================================
  logic [NUM_EXT-1:0] trig_r, enable_r, prio_r;
  logic global_en_r;
  logic [NUM_EXT-1:0] flag_r, flag_nxt;
  logic [EVT_W-1:0] evt_r, evt_nxt, evt_mask_r;
  logic prog_lo_r, prog_hi_r;
  logic access_w, wr_w, mapped_w;
  logic [31:0] rd_word;

  assign access_w = psel && penable && pready;
  assign wr_w = access_w && pwrite;

  always_comb begin
    mapped_w = 1'b1;
    rd_word = RST_WORD;
    case (paddr)
      OFS_TRIGGER: rd_word = 32'(trig_r);
      OFS_ENABLE: rd_word = 32'(enable_r) | (32'(global_en_r) << GLOBAL_EN_BIT);
      OFS_PRIORITY: rd_word = 32'(prio_r);
      OFS_FLAGS: rd_word = 32'(flag_r);
      OFS_PROGRESS: rd_word = {30'h0000_0000, prog_hi_r, prog_lo_r};
      OFS_EVT_STATUS: rd_word = 32'(evt_r);
      OFS_EVT_MASK: rd_word = 32'(evt_mask_r);
      default: mapped_w = 1'b0;
    endcase
  end

  // One wait state: the answer comes in the second access cycle.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= RST_WORD;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped_w;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? RST_WORD : rd_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trig_r <= '0;
      enable_r <= '0;
      global_en_r <= 1'b0;
      prio_r <= '0;
      evt_mask_r <= RST_EVT;
    end else if (wr_w) begin
      case (paddr)
        OFS_TRIGGER: trig_r <= pwdata[NUM_EXT-1:0]; // R1
        OFS_ENABLE: begin
          enable_r <= pwdata[NUM_EXT-1:0];
          global_en_r <= pwdata[GLOBAL_EN_BIT];
        end
        OFS_PRIORITY: prio_r <= pwdata[NUM_EXT-1:0];
        OFS_EVT_MASK: evt_mask_r <= pwdata[EVT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Request flags
  // ==========================================================================
  logic [NUM_EXT-1:0] req_prev_r, poll_r;
  logic take_w;
  logic [VID_W-1:0] take_idx;

  // A sample at state five wins over a software write or a call clear.
  always_comb begin
    flag_nxt = flag_r;
    if (wr_w && paddr == OFS_FLAGS) begin
      flag_nxt = pwdata[NUM_EXT-1:0]; // R15
    end
    if (take_w && trig_r[take_idx]) begin
      flag_nxt[take_idx] = 1'b0; // R4
    end
    if (s5_w) begin
      for (int i = 0; i < NUM_EXT; i++) begin
        if (!trig_r[i]) begin
          flag_nxt[i] = req_s[i]; // R6
        end else if (req_s[i] && !req_prev_r[i]) begin
          flag_nxt[i] = 1'b1; // R4
        end
      end
    end
  end

  // The poll copy takes the flags as they stood at the previous sample.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_r <= '0;
      req_prev_r <= '0;
      poll_r <= '0;
    end else begin
      flag_r <= flag_nxt;
      if (s5_w) begin
        req_prev_r <= req_s;
        poll_r <= flag_r; // R6 R8
      end
    end
  end

  // ==========================================================================
  // Poll and vector decision
  // ==========================================================================
  eidr_call_t call_st_r;
  logic [3:0] call_cnt_r;
  logic special_pend_r;
  logic [NUM_EXT-1:0] cand_w, hi_w, lo_w;
  logic gate_w;
  logic take_hi_w, take_lo_w;
  logic [NUM_EXT-1:0] denied_r;
  logic lost_w;

  assign cand_w = poll_r & enable_r & {NUM_EXT{global_en_r}};
  assign hi_w = cand_w & prio_r;
  assign lo_w = cand_w & ~prio_r;
  // R9 R10 R11
  assign gate_w = s6_w && call_st_r == EIDR_IDLE && instr_last_cycle && !instr_special &&
                  !special_pend_r;
  assign take_hi_w = gate_w && (|hi_w) && !prog_hi_r; // R14
  assign take_lo_w = gate_w && !(|hi_w) && (|lo_w) && !prog_hi_r && !prog_lo_r; // R12
  assign take_w = take_hi_w || take_lo_w;
  assign take_idx = first_set(MAX_EXT'(take_hi_w ? hi_w : lo_w));
  assign lost_w = s6_w && |(denied_r & ~cand_w); // R13

  // An enable or priority write acts like such an instruction in progress.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      special_pend_r <= 1'b0;
    end else if (wr_w && (paddr == OFS_ENABLE || paddr == OFS_PRIORITY)) begin
      special_pend_r <= 1'b1; // R10
    end else if (s6_w && instr_last_cycle) begin
      special_pend_r <= 1'b0;
    end
  end

  // Denied requests are only watched for reporting; nothing re-raises them.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      denied_r <= '0;
    end else if (s6_w) begin
      denied_r <= take_w ? (cand_w & ~(NUM_EXT'(1) << take_idx)) : cand_w; // R13
    end
  end

  // R7
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      call_st_r <= EIDR_IDLE;
      call_cnt_r <= '0;
      vector_id <= '0;
    end else begin
      case (call_st_r)
        EIDR_IDLE: begin
          if (take_w) begin
            call_st_r <= EIDR_CALL;
            call_cnt_r <= '0;
            vector_id <= take_idx;
          end
        end
        EIDR_CALL: begin
          call_cnt_r <= call_cnt_r + 4'h1;
          if (call_cnt_r == CALL_LAST) begin
            call_st_r <= EIDR_IDLE;
          end
        end
        default: call_st_r <= EIDR_IDLE;
      endcase
    end
  end

  assign call_active = (call_st_r == EIDR_CALL);

  // A return ends the highest level in progress.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prog_lo_r <= 1'b0;
      prog_hi_r <= 1'b0;
    end else begin
      if (take_hi_w) begin
        prog_hi_r <= 1'b1; // R12
      end else if (return_from_interrupt_instr && prog_hi_r) begin
        prog_hi_r <= 1'b0;
      end
      if (take_lo_w) begin
        prog_lo_r <= 1'b1; // R12
      end else if (return_from_interrupt_instr && !prog_hi_r) begin
        prog_lo_r <= 1'b0;
      end
    end
  end

  assign level_in_progress = {prog_hi_r, prog_lo_r};

  // ==========================================================================
  // Event status and interrupt output
  // ==========================================================================
  always_comb begin
    evt_nxt = evt_r;
    if (wr_w && paddr == OFS_EVT_STATUS) begin
      evt_nxt = evt_r & ~pwdata[EVT_W-1:0];
    end
    // Set wins over a clear written in the same cycle.
    evt_nxt[EVT_TAKEN_BIT] = evt_nxt[EVT_TAKEN_BIT] | take_w;
    evt_nxt[EVT_LOST_BIT] = evt_nxt[EVT_LOST_BIT] | lost_w;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_r <= RST_EVT;
      irq <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      irq <= |(evt_nxt & evt_mask_r);
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_call_two_cycles: assert property ($rose(call_active) |-> // R7
    call_active [*8] ##1 call_active [*4] ##1 !call_active)
    else $error("call did not last two machine cycles");
  a_edge_sets_flag: assert property (s5_w && trig_r[0] && req_s[0] && !req_prev_r[0] // R4
    |=> flag_r[0])
    else $error("falling pin did not set edge flag");
  a_call_clears_edge: assert property (take_w && trig_r[take_idx] && !s5_w // R4
    |=> !flag_r[$past(take_idx)])
    else $error("edge flag not cleared by call");
  a_level_follows_pin: assert property (s5_w && !trig_r[0] |=> flag_r[0] == $past(req_s[0])) // R6
    else $error("level flag does not follow pin");
  a_poll_last_cycle: assert property ($rose(call_active) |-> // R9
    $past(instr_last_cycle) && $past(mc_r) == EIDR_S6)
    else $error("vectored outside final instruction cycle");
  a_special_blocks: assert property (instr_special || special_pend_r |-> !take_w) // R10
    else $error("vectored during return or enable access");
  a_equal_level_block: assert property (prog_lo_r && !(|hi_w) |-> !take_w) // R12
    else $error("low request taken while low runs");
  a_high_preempts: assert property (gate_w && (|hi_w) && !prog_hi_r |=> // R14
    call_active && prog_hi_r)
    else $error("high request did not preempt");
  a_min_latency: assert property (s6_w && $rose(flag_r[0]) && !(|poll_r) && !call_active |-> // R8
    !take_w [*6])
    else $error("request taken before next poll cycle");
  a_lost_reported: assert property (lost_w |=> evt_r[EVT_LOST_BIT]) // R13
    else $error("denied request loss not reported");

  c_call_taken: cover property ($rose(call_active));
  c_preempt: cover property (prog_lo_r && take_hi_w);
  c_lost: cover property (lost_w);
  c_return: cover property (return_from_interrupt_instr && prog_lo_r);

endmodule : eidr_top
`default_nettype wire

//--- testbench/eidr_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module eidr_src_model import eidr_pkg::*; #(
  parameter int N = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Wanted pin state, one means asserted
  input wire logic [N-1:0] want_low,
  // Request pins, idle high as with a pull-up
  output logic [N-1:0] pin_n
);
  // Each level stays a full machine cycle, so a slow request is never missed.
  int hold [N];
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (!rst_b) begin
        pin_n[i] <= 1'b1;
        hold[i] <= 0;
      end else if (hold[i] < MC_STATES) begin
        hold[i] <= hold[i] + 1;
      end else if (pin_n[i] === want_low[i]) begin
        pin_n[i] <= ~want_low[i];
        hold[i] <= 0;
      end
    end
  end
endmodule : eidr_src_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top import eidr_pkg::*; ;
  logic clk, rst_b, psel, penable, pwrite, err;
  logic instr_last_cycle, instr_special, ret_pulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, call_active, irq;
  logic [VID_W-1:0] vector_id;
  logic [1:0] level_in_progress;
  logic [6:0] want_low, pin_n;
  int n_fail, n_checks, cyc;

  eidr_top #(.NUM_EXT(7)) i_eidr_top (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_request_pin_n(pin_n),
    .instr_last_cycle(instr_last_cycle), .instr_special(instr_special),
    .return_from_interrupt_instr(ret_pulse), .call_active(call_active),
    .vector_id(vector_id), .level_in_progress(level_in_progress), .irq(irq));
  eidr_src_model #(.N(7)) i_eidr_src_model (.clk(clk), .rst_b(rst_b),
    .want_low(want_low), .pin_n(pin_n));

  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input int exp, input logic [31:0] got);
    n_checks++;
    if (got !== 32'(exp)) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic cfg(input logic [31:0] trig, input logic [31:0] en, input logic [31:0] pri);
    apb(1'b1, OFS_TRIGGER, trig);
    apb(1'b1, OFS_ENABLE, en | 32'h8000_0000);
    apb(1'b1, OFS_PRIORITY, pri);
    apb(1'b1, OFS_EVT_MASK, 32'h0000_0003);
  endtask : cfg

  // Waits for a call, then checks its source and its length in clocks.
  task automatic take_call(input int vid, output int n);
    int len;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (call_active !== 1'b1 && n < 100);
    chk("call seen", 1, 32'(call_active));
    chk("vector", vid, 32'(vector_id));
    len = 0;
    do begin
      len++;
      @(posedge clk);
    end while (call_active === 1'b1 && len < 40);
    chk("call length", CALL_CLKS, 32'(len));
  endtask : take_call

  task automatic quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(posedge clk);
      if (call_active !== 1'b0) hits++;
    end
    chk("no call", 0, 32'(hits));
  endtask : quiet

  task automatic ret();
    ret_pulse <= 1'b1;
    @(posedge clk);
    ret_pulse <= 1'b0;
    @(posedge clk);
  endtask : ret

  // ==========================================
  // Scenarios
  task automatic t_regs();
    for (int a = 0; a <= 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0000_0000);
      chk("reset word", 0, q);
    end
    apb(1'b1, 8'h1C, 32'h0000_FFFF);
    chk("unmapped err", 1, 32'(err));
    apb(1'b1, OFS_TRIGGER, 32'hFFFF_FFFF);
    apb(1'b0, OFS_TRIGGER, 32'h0000_0000);
    chk("trigger bits", 'h7F, q);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_edge();
    int n;
    cfg(32'h0000_007F, 32'h0000_0001, 32'h0000_0000);
    want_low <= 7'h01;
    take_call(0, n);
    chk("latency", 1, 32'(n + CALL_CLKS > 3 * MC_STATES && n < 9 * MC_STATES));
    apb(1'b0, OFS_FLAGS, 32'h0000_0000);
    chk("edge flag", 0, q);
    apb(1'b0, OFS_EVT_STATUS, 32'h0000_0000);
    chk("taken", 1, q);
    chk("irq set", 1, 32'(irq));
    apb(1'b1, OFS_EVT_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq clear", 0, 32'(irq));
    ret();
    quiet(40);
    want_low <= 7'h00;
    $display("t_edge done");
  endtask : t_edge

  task automatic t_level();
    int n;
    cfg(32'h0000_0000, 32'h0000_0002, 32'h0000_0000);
    want_low <= 7'h02;
    take_call(1, n);
    chk("low busy", 1, 32'(level_in_progress));
    apb(1'b0, OFS_FLAGS, 32'h0000_0000);
    chk("level flag", 2, q);
    quiet(40);
    want_low <= 7'h00;
    repeat (20) @(posedge clk);
    ret();
    chk("none busy", 0, 32'(level_in_progress));
    quiet(30);
    $display("t_level done");
  endtask : t_level

  task automatic t_prio();
    int n;
    cfg(32'h0000_0000, 32'h0000_001C, 32'h0000_0010);
    want_low <= 7'h04;
    take_call(2, n);
    want_low <= 7'h0C;
    quiet(40);
    want_low <= 7'h1C;
    take_call(4, n);
    chk("both busy", 3, 32'(level_in_progress));
    want_low <= 7'h0C;
    repeat (20) @(posedge clk);
    ret();
    chk("low busy", 1, 32'(level_in_progress));
    quiet(30);
    want_low <= 7'h00;
    repeat (20) @(posedge clk);
    ret();
    chk("none busy", 0, 32'(level_in_progress));
    $display("t_prio done");
  endtask : t_prio

  task automatic t_block();
    int n;
    cfg(32'h0000_0000, 32'h0000_0020, 32'h0000_0000);
    apb(1'b1, OFS_EVT_STATUS, 32'h0000_0003);
    instr_last_cycle <= 1'b0;
    want_low <= 7'h20;
    quiet(40);
    instr_special <= 1'b1;
    instr_last_cycle <= 1'b1;
    quiet(40);
    want_low <= 7'h00;
    repeat (20) @(posedge clk);
    instr_special <= 1'b0;
    quiet(40);
    apb(1'b0, OFS_EVT_STATUS, 32'h0000_0000);
    chk("lost", 2, q & 32'h0000_0002);
    apb(1'b1, OFS_EVT_STATUS, 32'h0000_0003);
    want_low <= 7'h20;
    take_call(5, n);
    want_low <= 7'h00;
    repeat (20) @(posedge clk);
    ret();
    $display("t_block done");
  endtask : t_block

  task automatic t_soft();
    int n;
    cfg(32'h0000_0040, 32'h0000_0040, 32'h0000_0000);
    apb(1'b1, OFS_FLAGS, 32'h0000_0040);
    take_call(6, n);
    ret();
    instr_last_cycle <= 1'b0;
    apb(1'b1, OFS_FLAGS, 32'h0000_0040);
    apb(1'b1, OFS_FLAGS, 32'h0000_0000);
    instr_last_cycle <= 1'b1;
    quiet(30);
    $display("t_soft done");
  endtask : t_soft

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // ==========================================
  // Clock, timeout and main sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // The whole run needs about 1000 cycles; the ceiling leaves wide margin.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    instr_last_cycle = 1'b1;
    instr_special = 1'b0;
    ret_pulse = 1'b0;
    want_low = 7'h00;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_edge();
    t_level();
    t_prio();
    t_block();
    t_soft();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
